// ==== hdl/rtr_defs.svh ====
`ifndef RTR_DEFS_SVH
`define RTR_DEFS_SVH
// register byte offsets
`define RTR_OFS_CFG 8'h00
`define RTR_OFS_SUCC_HOLD 8'h04
`define RTR_OFS_FAIL_HOLD 8'h08
`define RTR_OFS_CMD 8'h0c
`define RTR_OFS_STATUS 8'h10
`define RTR_OFS_ACTIVE 8'h14
// configuration field positions
`define RTR_CFG_PORT_LSB 0
`define RTR_CFG_SER_FC_BIT 2
`define RTR_CFG_NET_FC_BIT 3
`define RTR_CFG_MAPA_LSB 4
`define RTR_CFG_MAPB_LSB 6
// command bits
`define RTR_CMD_TRIG_BIT 0
`define RTR_CMD_SAVE_BIT 1
// reset values
`define RTR_CFG_RST 8'h00
`define RTR_SUCC_HOLD_RST 16'h0064
`define RTR_FAIL_HOLD_RST 16'h0064
// timing, in their own units
`define RTR_CLK_NS 8
`define RTR_TICK_NS 1000000
`define RTR_CHATTER_MS 10
`define RTR_BEEP_SHORT_MS 60
`define RTR_BEEP_LONG_MS 300
`define RTR_BEEP_GAP_MS 100
`define RTR_BLINK_MS 100
`define RTR_POWERUP_LONG 2
`define RTR_POWERUP_SHORT 3
`define RTR_GOOD_SHORT 1
`endif

// ==== hdl/rtr_pkg.sv ====
package rtr_pkg;
	typedef enum logic [2:0] {
		RTR_IDLE = 3'b000,
		RTR_DEBOUNCE = 3'b001,
		RTR_READ = 3'b010,
		RTR_SEND = 3'b011
	} rtr_state_e;
	typedef enum logic [1:0] {
		RTR_MAP_RESULT = 2'b00,
		RTR_MAP_READY = 2'b01,
		RTR_MAP_BUSY1 = 2'b10,
		RTR_MAP_BUSY2 = 2'b11
	} rtr_map_e;
	typedef enum logic [1:0] {
		RTR_PORT_SERIAL = 2'b00,
		RTR_PORT_NETWORK = 2'b01,
		RTR_PORT_BOTH = 2'b10
	} rtr_port_e;
	typedef logic [15:0] rtr_hold_t;
endpackage : rtr_pkg

// ==== hdl/rtr_io.sv ====
// Functional notes
// - ready light is on whenever a read request can be accepted
// - trigger light turns on when any trigger source starts a read
// - success light turns on when a read decodes at least one symbol
// - failure light turns on when a read completes without decode
// - success output holds for success hold time, drops at next read
// - failure output holds for failure hold time, drops at next read
// - output mapped as ready is on while a new read is accepted
// - busy variant one: on while reading, not debouncing, off after decode
// - busy variant two: like one but off after result transmission
// - default mapping success/failure; remap applies after save and reset
// - trigger pin active level or port command starts a read
// - exactly three trigger sources: port command, pin, button; code also starts a read from the CMD register trigger bit
// - good read: one short beep, send data, success output and light
// - failed read: no beep, send error code, failure output and light
// - port select 0 serial, 1 network, 2 both
// - both ports and one refuses data: stall all result output; code stalls only tx_start, result outputs and lights still follow
// - selected port carries commands in and results out
// - after power-up light ready, then two long and three short beeps
// - network link light steady on link, activity light blinks
`include "rtr_defs.svh"
module rtr_io import rtr_pkg::*; #(
	parameter int TICK_CYCLES = `RTR_TICK_NS / `RTR_CLK_NS
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic por,
	input wire logic ce,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// trigger sources
	input wire logic trig_pin,
	input wire logic read_button,
	input wire logic ser_cmd_trig,
	input wire logic net_cmd_trig,
	// decode engine
	output logic read_start,
	input wire logic decode_done,
	input wire logic decode_ok,
	// result transmission
	output logic tx_start,
	output logic tx_ser_en,
	output logic tx_net_en,
	output logic tx_is_error,
	input wire logic tx_done,
	input wire logic ser_refuse,
	input wire logic net_refuse,
	// network status
	input wire logic net_link,
	input wire logic net_activity,
	// indicators, beeper, isolated outputs
	output logic led_ready,
	output logic led_trigger,
	output logic led_success,
	output logic led_failure,
	output logic led_net_link,
	output logic led_net_act,
	output logic beep,
	output logic out_a,
	output logic out_b
);
	localparam int CHAT_CYC = `RTR_CHATTER_MS * TICK_CYCLES;

	// pin synchronisers: first stage read only by second
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic trig_prev_reg;
	logic btn_prev_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
		end else if (ce) begin
			sync1_reg <= {net_activity, net_link, read_button, trig_pin};
			sync2_reg <= sync1_reg;
		end
	end

	// millisecond tick
	logic [31:0] tick_cnt_reg;
	logic tick;
	assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
	always_ff @(posedge clk) begin
		if (rst || (ce && tick)) begin
			tick_cnt_reg <= 32'h0;
		end else if (ce) begin
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
		end
	end

	// software configuration
	logic [7:0] cfg_reg;
	logic [7:0] saved_reg;
	logic [7:0] active_reg;
	rtr_hold_t succ_hold_reg;
	rtr_hold_t fail_hold_reg;
	logic soft_trig_reg;
	logic wb_hit;
	logic wb_wr;
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_hit && wb_we_i;

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_reg <= `RTR_CFG_RST;
			succ_hold_reg <= `RTR_SUCC_HOLD_RST;
			fail_hold_reg <= `RTR_FAIL_HOLD_RST;
		end else if (ce && wb_wr && wb_sel_i[0]) begin
			if (wb_adr_i == `RTR_OFS_CFG) begin
				cfg_reg <= wb_dat_i[7:0];
			end
			if (wb_adr_i == `RTR_OFS_SUCC_HOLD) begin
				succ_hold_reg[7:0] <= wb_dat_i[7:0];
			end
			if (wb_adr_i == `RTR_OFS_FAIL_HOLD) begin
				fail_hold_reg[7:0] <= wb_dat_i[7:0];
			end
		end
		if (!rst && ce && wb_wr && wb_sel_i[1]) begin
			if (wb_adr_i == `RTR_OFS_SUCC_HOLD) begin
				succ_hold_reg[15:8] <= wb_dat_i[15:8];
			end
			if (wb_adr_i == `RTR_OFS_FAIL_HOLD) begin
				fail_hold_reg[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// saved copy survives rst, mapping is taken up only at reset
	always_ff @(posedge clk) begin
		if (por) begin
			saved_reg <= `RTR_CFG_RST;
		end else if (ce && wb_wr && wb_sel_i[0] && wb_adr_i == `RTR_OFS_CMD
				&& wb_dat_i[`RTR_CMD_SAVE_BIT]) begin
			saved_reg <= cfg_reg;
		end
	end
	always_ff @(posedge clk) begin
		if (por) begin
			active_reg <= `RTR_CFG_RST;
		end else if (rst) begin
			active_reg <= saved_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			soft_trig_reg <= 1'b0;
		end else if (ce) begin
			soft_trig_reg <= wb_wr && wb_sel_i[0]
				&& wb_adr_i == `RTR_OFS_CMD && wb_dat_i[`RTR_CMD_TRIG_BIT];
		end
	end

	rtr_port_e port_sel;
	logic use_ser;
	logic use_net;
	assign port_sel = rtr_port_e'(cfg_reg[`RTR_CFG_PORT_LSB +: 2]);
	assign use_ser = (port_sel == RTR_PORT_SERIAL)
		|| (port_sel == RTR_PORT_BOTH);
	assign use_net = (port_sel == RTR_PORT_NETWORK)
		|| (port_sel == RTR_PORT_BOTH);

	// five sources; pin or button edge, register command or port command
	logic pin_start;
	logic cmd_start;
	assign pin_start = (sync2_reg[0] && !trig_prev_reg)
		|| (sync2_reg[1] && !btn_prev_reg);
	// commands only accepted on the selected port
	assign cmd_start = soft_trig_reg || (ser_cmd_trig && use_ser)
		|| (net_cmd_trig && use_net);
	always_ff @(posedge clk) begin
		if (rst) begin
			trig_prev_reg <= 1'b0;
			btn_prev_reg <= 1'b0;
		end else if (ce) begin
			trig_prev_reg <= sync2_reg[0];
			btn_prev_reg <= sync2_reg[1];
		end
	end

	// stall when both ports selected and one refuses
	logic tx_stall;
	assign tx_stall = (port_sel == RTR_PORT_BOTH) && (ser_refuse || net_refuse);

	// read sequencer
	rtr_state_e state_reg;
	logic [31:0] chat_cnt_reg;
	logic result_ok_reg;
	logic tx_pend_reg;
	logic result_evt;
	assign result_evt = (state_reg == RTR_READ) && decode_done;
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= RTR_IDLE;
			chat_cnt_reg <= 32'h0;
			result_ok_reg <= 1'b0;
			tx_pend_reg <= 1'b0;
			read_start <= 1'b0;
			tx_start <= 1'b0;
		end else if (ce) begin
			read_start <= 1'b0;
			tx_start <= 1'b0;
			unique case (state_reg)
				RTR_IDLE: begin
					if (cmd_start) begin
						state_reg <= RTR_READ;
						read_start <= 1'b1;
					end else if (pin_start) begin
						state_reg <= RTR_DEBOUNCE;
						chat_cnt_reg <= 32'h0;
					end
				end
				RTR_DEBOUNCE: begin
					chat_cnt_reg <= chat_cnt_reg + 32'h1;
					if (chat_cnt_reg == 32'(CHAT_CYC - 1)) begin
						state_reg <= RTR_READ;
						read_start <= 1'b1;
					end
				end
				RTR_READ: begin
					if (decode_done) begin
						result_ok_reg <= decode_ok;
						tx_pend_reg <= 1'b1;
						state_reg <= RTR_SEND;
					end
				end
				RTR_SEND: begin
					// send data or error once not stalled
					if (tx_pend_reg && !tx_stall) begin
						tx_start <= 1'b1;
						tx_pend_reg <= 1'b0;
					end else if (!tx_pend_reg && tx_done) begin
						state_reg <= RTR_IDLE;
					end
				end
				default: state_reg <= RTR_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_ser_en <= 1'b0;
			tx_net_en <= 1'b0;
			tx_is_error <= 1'b0;
		end else if (ce) begin
			// results leave on the selected port
			tx_ser_en <= use_ser;
			tx_net_en <= use_net;
			tx_is_error <= !result_ok_reg;
		end
	end

	// result hold timers
	rtr_hold_t succ_cnt_reg;
	rtr_hold_t fail_cnt_reg;
	logic succ_on_reg;
	logic fail_on_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			succ_on_reg <= 1'b0;
			fail_on_reg <= 1'b0;
			succ_cnt_reg <= '0;
			fail_cnt_reg <= '0;
		end else if (ce) begin
			// new read clears both held results
			if (read_start) begin
				succ_on_reg <= 1'b0;
				fail_on_reg <= 1'b0;
			end else if (result_evt) begin
				// at most one of the two is raised; none if its hold time is zero
				succ_on_reg <= decode_ok && (succ_hold_reg != '0);
				fail_on_reg <= !decode_ok && (fail_hold_reg != '0);
				succ_cnt_reg <= succ_hold_reg;
				fail_cnt_reg <= fail_hold_reg;
			end else if (tick) begin
				if (succ_on_reg) begin
					succ_cnt_reg <= succ_cnt_reg - 16'h1;
					succ_on_reg <= (succ_cnt_reg != 16'h1);
				end
				if (fail_on_reg) begin
					fail_cnt_reg <= fail_cnt_reg - 16'h1;
					fail_on_reg <= (fail_cnt_reg != 16'h1);
				end
			end
		end
	end

	// status terms
	logic ready;
	logic busy1;
	logic busy2;
	assign ready = (state_reg == RTR_IDLE);
	assign busy1 = (state_reg == RTR_READ);
	assign busy2 = busy1 || (state_reg == RTR_SEND);

	function automatic logic map_out(input logic [1:0] m, input logic res);
		unique case (rtr_map_e'(m))
			RTR_MAP_RESULT: map_out = res;
			RTR_MAP_READY: map_out = ready;
			RTR_MAP_BUSY1: map_out = busy1;
			RTR_MAP_BUSY2: map_out = busy2;
		endcase
	endfunction : map_out

	// isolated outputs and indicators
	always_ff @(posedge clk) begin
		if (rst) begin
			out_a <= 1'b0;
			out_b <= 1'b0;
			led_ready <= 1'b0;
			led_trigger <= 1'b0;
			led_success <= 1'b0;
			led_failure <= 1'b0;
		end else if (ce) begin
			out_a <= map_out(active_reg[`RTR_CFG_MAPA_LSB +: 2], succ_on_reg);
			out_b <= map_out(active_reg[`RTR_CFG_MAPB_LSB +: 2], fail_on_reg);
			led_ready <= ready;
			// trigger light from start until result
			if (read_start || (state_reg == RTR_DEBOUNCE)) begin
				led_trigger <= 1'b1;
			end else if (result_evt) begin
				led_trigger <= 1'b0;
			end
			// result lights follow the hold timers
			led_success <= succ_on_reg;
			led_failure <= fail_on_reg;
		end
	end

	logic [15:0] blink_cnt_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			led_net_link <= 1'b0;
			led_net_act <= 1'b0;
			blink_cnt_reg <= 16'h0;
		end else if (ce) begin
			led_net_link <= sync2_reg[2];
			if (!sync2_reg[3]) begin
				led_net_act <= 1'b0;
				blink_cnt_reg <= 16'h0;
			end else if (tick) begin
				if (blink_cnt_reg == 16'(`RTR_BLINK_MS - 1)) begin
					blink_cnt_reg <= 16'h0;
					led_net_act <= !led_net_act;
				end else begin
					blink_cnt_reg <= blink_cnt_reg + 16'h1;
				end
			end
		end
	end

	// beeper: longs first, then shorts, gap between tones
	logic [1:0] longs_reg;
	logic [4:0] shorts_reg;
	logic [15:0] beep_cnt_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			longs_reg <= 2'(`RTR_POWERUP_LONG);
			shorts_reg <= 5'(`RTR_POWERUP_SHORT);
			beep_cnt_reg <= 16'h0;
			beep <= 1'b0;
		end else if (ce) begin
			// good read adds one short beep; none on failure
			// queue saturates: a burst of reads drops beeps, never wraps
			if (result_evt && decode_ok && shorts_reg != 5'h1f) begin
				shorts_reg <= shorts_reg + 5'(`RTR_GOOD_SHORT);
			end
			if (tick) begin
				if (beep_cnt_reg != 16'h0) begin
					beep_cnt_reg <= beep_cnt_reg - 16'h1;
				end else if (beep) begin
					beep <= 1'b0;
					beep_cnt_reg <= 16'(`RTR_BEEP_GAP_MS - 1);
				end else if (longs_reg != 2'h0) begin
					beep <= 1'b1;
					longs_reg <= longs_reg - 2'h1;
					beep_cnt_reg <= 16'(`RTR_BEEP_LONG_MS - 1);
				end else if (shorts_reg != 5'h00
						&& !(result_evt && decode_ok)) begin
					beep <= 1'b1;
					shorts_reg <= shorts_reg - 5'h01;
					beep_cnt_reg <= 16'(`RTR_BEEP_SHORT_MS - 1);
				end
			end
		end
	end

	// register reads; unmapped offsets read zero
	logic [31:0] rd_data;
	always_comb begin
		rd_data = 32'h0;
		unique case (wb_adr_i)
			`RTR_OFS_CFG: rd_data = {24'h0, cfg_reg};
			`RTR_OFS_SUCC_HOLD: rd_data = {16'h0, succ_hold_reg};
			`RTR_OFS_FAIL_HOLD: rd_data = {16'h0, fail_hold_reg};
			`RTR_OFS_STATUS: rd_data = {20'h0, tx_stall, beep, fail_on_reg,
				succ_on_reg, busy2, busy1, ready, 2'h0, state_reg};
			`RTR_OFS_ACTIVE: rd_data = {16'h0, saved_reg, active_reg};
			default: rd_data = 32'h0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else if (ce) begin
			wb_ack_o <= wb_hit;
			wb_dat_o <= wb_hit ? rd_data : 32'h0;
		end
	end
endmodule : rtr_io

// ==== sim/rtr_io_asserts.sv ====
module rtr_io_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// observed ports
	input wire logic read_start,
	input wire logic decode_done,
	input wire logic decode_ok,
	input wire logic tx_start,
	input wire logic tx_ser_en,
	input wire logic tx_net_en,
	input wire logic ser_refuse,
	input wire logic net_refuse,
	input wire logic led_ready,
	input wire logic led_trigger,
	input wire logic led_success,
	input wire logic led_failure
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_good;
		decode_done && decode_ok;
	endsequence
	sequence s_bad;
		decode_done && !decode_ok;
	endsequence
	property p_ready;
		read_start |=> !led_ready;
	endproperty
	a_ready: assert property (p_ready) else $error("ready lit");
	property p_trig;
		read_start |-> ##[0:1] led_trigger;
	endproperty
	a_trig: assert property (p_trig) else $error("no trig led");
	property p_good;
		s_good |-> ##[1:2] led_success;
	endproperty
	a_good: assert property (p_good) else $error("no success");
	property p_bad;
		s_bad |-> ##[1:2] led_failure;
	endproperty
	a_bad: assert property (p_bad) else $error("no failure");
	property p_clear;
		read_start |-> ##[1:2] !(led_success || led_failure);
	endproperty
	a_clear: assert property (p_clear) else $error("not cleared");
	property p_excl;
		!(led_success && led_failure);
	endproperty
	a_excl: assert property (p_excl) else $error("both lit");
	property p_stall;
		tx_start && tx_ser_en && tx_net_en
			|-> !$past(ser_refuse || net_refuse);
	endproperty
	a_stall: assert property (p_stall) else $error("sent on refuse");
	property p_port;
		tx_start |-> tx_ser_en || tx_net_en;
	endproperty
	a_port: assert property (p_port) else $error("no port");
endmodule : rtr_io_asserts
bind rtr_io rtr_io_asserts u_rtr_io_asserts (.clk, .rst, .read_start,
	.decode_done, .decode_ok, .tx_start, .tx_ser_en, .tx_net_en,
	.ser_refuse, .net_refuse, .led_ready, .led_trigger, .led_success,
	.led_failure);

// ==== sim/rtr_io_host.sv ====
module rtr_io_host (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bench control
	input wire logic ok_i,
	input wire logic slow_i,
	// engine and port side
	input wire logic read_start,
	input wire logic tx_start,
	output logic decode_done,
	output logic decode_ok,
	output logic tx_done,
	output logic ser_refuse,
	output logic net_refuse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] dec_reg;
	logic [5:0] tx_reg;
	logic [5:0] cnt_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			dec_reg <= 6'h00;
			tx_reg <= 6'h00;
			cnt_reg <= 6'h00;
		end else begin
			cnt_reg <= cnt_reg + 6'h01;
			if (read_start)
				dec_reg <= slow_i ? 6'h14 : 6'h02;
			else if (dec_reg != 6'h00)
				dec_reg <= dec_reg - 6'h01;
			if (tx_start)
				tx_reg <= slow_i ? 6'h0c : 6'h02;
			else if (tx_reg != 6'h00)
				tx_reg <= tx_reg - 6'h01;
		end
	end
	assign decode_done = dec_reg == 6'h01;
	// ok toggles outside the done pulse so no stale value can be relied on
	assign decode_ok = decode_done ? ok_i : cnt_reg[0];
	assign tx_done = tx_reg == 6'h01;
	// short refusal bursts keep the stall path busy
	assign ser_refuse = cnt_reg[5:3] == 3'h7;
	assign net_refuse = cnt_reg[5:2] == 4'h9;
endmodule : rtr_io_host

// ==== sim/rtr_io_tb.sv ====
module rtr_io_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, por, cyc, stb, we, pin, btn, scmd, ncmd, ok, slow;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, q, dout;
	logic ack, rs, dd, dok, txs, sen, nen, err, txd, sref, nref;
	logic ledr, ledt, leds, ledf, out_a, out_b;
	logic [1:0] en_cap;
	logic [1:0] ab_cap;
	logic err_cap;
	logic bp, bp_q, lnk, act, lnet, nact, nact_q;
	int bad_count, comparisons, la, lb, n, p, src, hs, hf, i;
	int starts, st0, goods, beeps, beep_hi, tg;
	int unsigned seed = 70892;
	rtr_io #(.TICK_CYCLES(4)) u_rtr_io (.clk, .rst, .por, .ce(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
		.trig_pin(pin), .read_button(btn), .ser_cmd_trig(scmd),
		.net_cmd_trig(ncmd), .read_start(rs), .decode_done(dd),
		.decode_ok(dok), .tx_start(txs), .tx_ser_en(sen), .tx_net_en(nen),
		.tx_is_error(err), .tx_done(txd), .ser_refuse(sref),
		.net_refuse(nref), .net_link(lnk), .net_activity(act),
		.led_ready(ledr), .led_trigger(ledt), .led_success(leds),
		.led_failure(ledf), .led_net_link(lnet), .led_net_act(nact),
		.beep(bp), .out_a, .out_b);
	rtr_io_host u_rtr_io_host (.clk, .rst, .ok_i(ok), .slow_i(slow),
		.read_start(rs), .tx_start(txs), .decode_done(dd), .decode_ok(dok),
		.tx_done(txd), .ser_refuse(sref), .net_refuse(nref));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		la <= rs ? 0 : la + out_a;
		lb <= rs ? 0 : lb + out_b;
		starts <= starts + rs;
		bp_q <= bp;
		beeps <= beeps + (bp && !bp_q);
		beep_hi <= beep_hi + bp;
		nact_q <= nact;
		tg <= tg + (nact != nact_q);
		if (txs) begin
			en_cap <= {nen, sen};
			err_cap <= err;
			ab_cap <= {out_b, out_a};
		end
	end
	function automatic int rnd(input int m);
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed % m;
	endfunction : rnd
	function automatic logic [1:0] exp_en(input int ps);
		return ps == 0 ? 2'h1 : (ps == 1 ? 2'h2 : 2'h3);
	endfunction : exp_en
	task conclude();
		$display("counts: %0d compared, %0d bad", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task chk_in(input int got, input int lo, input int hi);
		comparisons++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("Error %0t count %0d not in %0d..%0d", $time, got, lo, hi);
		end
	endtask : chk_in
	task tmo();
		bad_count++;
		$display("Error %0t wait ran out", $time);
		conclude();
	endtask : tmo
	// read_start is a one-cycle pulse: wait on the count it leaves behind
	task wt(input int k);
		repeat (400) begin
			@(posedge clk);
			if (k == 0 ? starts != st0 : ledr === 1'b1)
				return;
		end
		tmo();
	endtask : wt
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'h3;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && i < 50);
		if (ack !== 1'b1)
			tmo();
		q = dout;
		cyc <= 0;
		stb <= 0;
		@(posedge clk);
	endtask : wb
	task pulse(input int s);
		if (s == 1)
			scmd <= 1;
		else
			ncmd <= 1;
		@(posedge clk);
		scmd <= 0;
		ncmd <= 0;
	endtask : pulse
	initial begin
		{rst, por} = 2'h3;
		{cyc, stb, we, pin, btn, scmd, ncmd, ok, slow} = 9'h000;
		{adr, sel, dat} = 44'h0;
		{lnk, act} = 2'h0;
		repeat (20) @(posedge clk);
		rst <= 0;
		por <= 0;
		repeat (2) @(posedge clk);
		chk(ledr, 1);
		wb(0, 8'h04, 0);
		chk(q, 32'h64);
		wb(0, 8'h08, 0);
		chk(q, 32'h64);
		wb(0, 8'h14, 0);
		chk(q, 32'h0);
		wb(0, 8'h24, 0);
		chk(q, 32'h0);
		hs = 2 + rnd(4);
		hf = 2 + rnd(4);
		wb(1, 8'h04, hs);
		wb(1, 8'h08, hf);
		wb(0, 8'h04, 0);
		chk(q, hs);
		$display("test reset done");
		for (n = 0; n < 14; n++) begin
			p = rnd(3);
			src = n < 5 ? n : rnd(5);
			ok <= rnd(2);
			slow <= rnd(2);
			wb(1, 8'h00, p | 32'hc);
			chk(ledr, 1);
			// a command from the port not selected must be ignored
			if ((src == 1 && p == 1) || (src == 2 && p == 0)) begin
				st0 = starts;
				pulse(src);
				repeat (12) @(posedge clk);
				chk(starts - st0, 0);
				src = 0;
			end
			st0 = starts;
			// every trigger source starts a read
			case (src)
				0: wb(1, 8'h0c, 1);
				1, 2: pulse(src);
				3: pin <= 1;
				default: btn <= 1;
			endcase
			wt(0);
			pin <= 0;
			btn <= 0;
			wt(1);
			repeat (4 * (hs > hf ? hs : hf) + 12) @(posedge clk);
			chk(en_cap, exp_en(p));
			chk(err_cap, !ok);
			chk_in(la, ok ? 4 * hs - 5 : 0, ok ? 4 * hs + 5 : 0);
			chk_in(lb, ok ? 0 : 4 * hf - 5, ok ? 0 : 4 * hf + 5);
			goods += ok;
			$display("test read %0d done", n);
		end
		// link steady, activity blinks while the queued tones play out
		lnk <= 1;
		act <= 1;
		i = 0;
		while ((beeps < 5 + goods || bp === 1'b1) && i < 20000) begin
			@(posedge clk);
			i++;
		end
		if (beeps < 5 + goods || bp === 1'b1)
			tmo();
		chk(beeps, 5 + goods);
		chk(beep_hi, 1200 * 2 + 240 * (3 + goods));
		chk(lnet, 1);
		chk_in(tg, i / 400 - 1, i / 400 + 1);
		lnk <= 0;
		act <= 0;
		repeat (4) @(posedge clk);
		chk({lnet, nact}, 2'h0);
		$display("test tones and lights done");
		// remap of out_a to ready, out_b to busy2, then out_a to busy1, takes effect after save and reset
		wb(1, 8'h00, 32'hdc);
		wb(1, 8'h0c, 32'h2);
		chk(out_a, 0);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		repeat (3) @(posedge clk);
		chk({out_b, out_a, ledr}, 3'h3);
		ok <= 1;
		st0 = starts;
		wb(1, 8'h0c, 1);
		wt(0);
		@(posedge clk);
		chk({out_b, out_a}, 2'h2);
		wt(1);
		chk({ab_cap[1], out_b}, 2'h2);
		wb(1, 8'h00, 32'h2c);
		wb(1, 8'h0c, 32'h2);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		repeat (3) @(posedge clk);
		chk(out_a, 0);
		slow <= 1;
		st0 = starts;
		wb(1, 8'h0c, 1);
		wt(0);
		@(posedge clk);
		chk(out_a, 1);
		wt(1);
		chk({ab_cap[0], out_a}, 2'h0);
		$display("test remap done");
		conclude();
	end
endmodule : rtr_io_tb
